// ---- shared/rssc_pkg.sv ----
// Package: constants and carrier types for the reset and start-up control.
package rssc_pkg;

  // ***********************************************************
  // Timing
  // ***********************************************************
  // One state time is three clock-input cycles (three phases).
  localparam int unsigned PHASE_COUNT = 3;
  localparam int unsigned RESET_MIN_STATES = 2;
  localparam int unsigned DRIVE_LOW_STATES = 2;
  localparam int unsigned SYNC_DELAY_CYCLES = 6;
  localparam int unsigned RESET_INSTR_STATES = 10;
  localparam int unsigned STATE_CNT_W = 4;

  // ***********************************************************
  // Power-down RAM window
  // ***********************************************************
  localparam logic [7:0] PD_RAM_FIRST = 8'hf0;
  localparam logic [7:0] PD_RAM_LAST = 8'hff;
  localparam int unsigned PD_RAM_DEPTH = 16;

  typedef enum logic [3:0] {
    RSSC_IN_RESET = 4'h1,
    RSSC_SYNC_WAIT = 4'h2,
    RSSC_RESET_INSTR = 4'h4,
    RSSC_RUN = 4'h8
  } rssc_state_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } rssc_ram_req_t;

  typedef struct packed {
    logic phase1;
    logic phase2;
    logic phase3;
    logic state_tick;
  } rssc_phase_t;

endpackage

// ---- logic/rssc_pd_ram.sv ----
// Power-down RAM: the retained window of internal RAM.
module rssc_pd_ram
  import rssc_pkg::*;
#(
  parameter int unsigned DEPTH = rssc_pkg::PD_RAM_DEPTH
)
(
  input wire logic ref_clk,
  input wire rssc_pkg::rssc_ram_req_t req,
  input wire logic standby_ok,
  output logic [7:0] rd_data,
  output logic hit
);
  import rssc_pkg::*;

  logic [7:0] mem [DEPTH];
  wire logic [3:0] idx = req.addr[3:0];

  // R10: window decode
  assign hit = (req.addr >= PD_RAM_FIRST) && (req.addr <= PD_RAM_LAST);

  // Not reset on purpose: contents must survive a device reset.
  always_ff @(posedge ref_clk)
  begin
    if (req.wr && hit && standby_ok)
    begin
      mem[idx] <= req.data;
    end
    rd_data <= mem[idx];
  end
endmodule // rssc_pd_ram

// ---- logic/rssc_reset_ctrl.sv ----
// Reset and start-up sequencer with watchdog pull-down latch.
// Operation
// R1: External source holds reset low at least two state times.
// R2: Watchdog overflow turns on and latches the reset-pin pull-down.
// R3: Clearing the watchdog counter never releases the pull-down latch.
// R4: Self-driven reset pulse lasts two state times when not held high.
// R5: Release on clock falling edge starts reset instruction six cycles later.
// R6: Strap high fetches internally; strap low forces external execution.
// R7: Strap has internal pulldown; a floating strap reads low.
// R8: Three-phase internal clock is derived from the clock input pin.
// R9: Clock source must run between 6.0 and 12 MHz.
// R10: Power-down RAM window 0F0H to 0FFH stays valid while standby powered.
// R11: Reset accepted only after continuous low for counted state times.
module rssc_reset_ctrl
  import rssc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clock_input_pin,
  input wire logic reset_pin_in,
  input wire logic external_access_strap,
  input wire logic strap_driven,
  input wire logic watchdog_overflow,
  input wire logic watchdog_clear,
  input wire logic software_reset,
  input wire logic standby_supply_pin,
  input wire rssc_pkg::rssc_ram_req_t ram_req,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic pulldown_latched,
  output logic core_reset,
  output logic reset_instr_active,
  output logic internal_exec,
  output rssc_pkg::rssc_phase_t phases,
  output logic [7:0] ram_rd_data,
  output logic ram_hit
);
  import rssc_pkg::*;

  // ***********************************************************
  // Input synchronisers
  // ***********************************************************
  logic [1:0] clk_sync;
  logic [1:0] rst_sync;
  logic [1:0] vpd_sync;
  logic [1:0] ea_sync;
  logic [1:0] drv_sync;
  logic clk_prev;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_sync <= 2'h0;
      rst_sync <= 2'h3;
      vpd_sync <= 2'h0;
      ea_sync <= 2'h0;
      drv_sync <= 2'h0;
      clk_prev <= 1'b0;
    end
    else
    begin
      clk_sync <= {clk_sync[0], clock_input_pin};
      rst_sync <= {rst_sync[0], reset_pin_in};
      vpd_sync <= {vpd_sync[0], standby_supply_pin};
      ea_sync <= {ea_sync[0], external_access_strap};
      drv_sync <= {drv_sync[0], strap_driven};
      clk_prev <= clk_sync[1];
    end
  end
  wire logic clk_s = clk_sync[1];
  wire logic pin_low = !rst_sync[1];
  wire logic clk_rise = clk_s && !clk_prev;
  wire logic clk_fall = !clk_s && clk_prev;

  // ***********************************************************
  // Three-phase clock
  // ***********************************************************
  logic [1:0] phase;
  // R8: phase rotation
  wire logic [1:0] next_phase =
    (phase == 2'(PHASE_COUNT - 1)) ? 2'h0 : phase + 2'h1;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase <= 2'h0;
    else if (clk_rise)
      phase <= next_phase;
  end
  wire logic tick = clk_rise && (phase == 2'(PHASE_COUNT - 1));
  // R9: state timing assumes the supplied input clock is in range.
  assign phases = '{phase1: phase == 2'h0, phase2: phase == 2'h1,
                    phase3: phase == 2'h2, state_tick: tick};

  // ***********************************************************
  // Reset input qualification
  // ***********************************************************
  // Counting input-clock cycles rather than state ticks keeps a pulse that
  // merely straddles two tick boundaries from being taken as a reset.
  localparam int unsigned LOW_EDGES = RESET_MIN_STATES * PHASE_COUNT;
  localparam int unsigned DRIVE_EDGES = DRIVE_LOW_STATES * PHASE_COUNT;
  logic [STATE_CNT_W-1:0] low_cnt;
  logic accepted;
  // R11: count continuous low input-clock cycles
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      low_cnt <= '0;
    else if (!pin_low)
      low_cnt <= '0;
    else if (clk_rise && low_cnt != STATE_CNT_W'(LOW_EDGES))
      low_cnt <= low_cnt + 1'b1;
  end
  // R1: held low two state times before acceptance
  assign accepted = pin_low && (low_cnt == STATE_CNT_W'(LOW_EDGES));

  // ***********************************************************
  // Pull-down latch and self-driven pulse
  // ***********************************************************
  logic latch;
  logic [STATE_CNT_W-1:0] drive_cnt;
  wire logic fire = watchdog_overflow || software_reset;
  // R2: overflow sets the latch
  // R3: watchdog clear has no path here; only reset releases it
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      latch <= 1'b0;
    else if (watchdog_overflow)
      latch <= 1'b1;
    else if (core_reset && !pin_low && drive_cnt == '0)
      latch <= 1'b0;
  end
  // R4: drive low for two state times
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      drive_cnt <= '0;
    else if (fire && drive_cnt == '0)
      drive_cnt <= STATE_CNT_W'(DRIVE_EDGES);
    else if (clk_rise && drive_cnt != '0)
      drive_cnt <= drive_cnt - 1'b1;
  end
  wire logic drive = (drive_cnt != '0) || (latch && !core_reset);
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = drive;
  assign pulldown_latched = latch;

  // ***********************************************************
  // Start-up sequencer
  // ***********************************************************
  rssc_state_t state;
  rssc_state_t next_state;
  logic [STATE_CNT_W-1:0] seq_cnt;
  logic [STATE_CNT_W-1:0] next_seq_cnt;
  always_comb
  begin
    next_state = state;
    next_seq_cnt = seq_cnt;
    unique case (state)
      RSSC_IN_RESET:
        // R5: release seen on falling edge starts the fixed delay
        if (!pin_low && clk_fall)
        begin
          next_state = RSSC_SYNC_WAIT;
          next_seq_cnt = STATE_CNT_W'(SYNC_DELAY_CYCLES - 1);
        end
      RSSC_SYNC_WAIT:
        if (clk_fall)
        begin
          if (seq_cnt == '0)
          begin
            next_state = RSSC_RESET_INSTR;
            next_seq_cnt = STATE_CNT_W'(RESET_INSTR_STATES - 1);
          end
          else
            next_seq_cnt = seq_cnt - 1'b1;
        end
      RSSC_RESET_INSTR:
        if (tick)
        begin
          if (seq_cnt == '0)
            next_state = RSSC_RUN;
          else
            next_seq_cnt = seq_cnt - 1'b1;
        end
      RSSC_RUN:
        if (accepted || drive)
          next_state = RSSC_IN_RESET;
      default:
        next_state = RSSC_IN_RESET;
    endcase
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= RSSC_IN_RESET;
      seq_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      seq_cnt <= next_seq_cnt;
    end
  end
  assign core_reset = (state == RSSC_IN_RESET) || (state == RSSC_SYNC_WAIT);
  assign reset_instr_active = (state == RSSC_RESET_INSTR);

  // ***********************************************************
  // Execution-source strap
  // ***********************************************************
  // R7: undriven strap reads low through the pulldown
  wire logic strap_level = drv_sync[1] && ea_sync[1];
  // R6: strap caught while the core is held in reset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      internal_exec <= 1'b0;
    else if (core_reset)
      internal_exec <= strap_level;
  end

  // ***********************************************************
  // Power-down RAM
  // ***********************************************************
  // R10: writes allowed only while standby supply is present
  rssc_pd_ram #(.DEPTH(PD_RAM_DEPTH)) u_pd_ram (
    .ref_clk(ref_clk),
    .req(ram_req),
    .standby_ok(vpd_sync[1]),
    .rd_data(ram_rd_data),
    .hit(ram_hit)
  );

  // ***********************************************************
  // Assertions
  // ***********************************************************
  a_latch_holds: assert property ( // R3
    @(posedge ref_clk) disable iff (!reset_n)
    latch && !core_reset |=> latch)
    else $error("pull-down latch dropped while running");
  a_clear_keeps: assert property ( // R3
    @(posedge ref_clk) disable iff (!reset_n)
    latch && watchdog_clear && !core_reset |=> latch)
    else $error("watchdog clear released pull-down latch");
  a_latch_sets: assert property ( // R2
    @(posedge ref_clk) disable iff (!reset_n)
    watchdog_overflow |=> latch && reset_pin_oe)
    else $error("overflow did not latch pull-down");
  a_reset_taken: assert property ( // R11
    @(posedge ref_clk) disable iff (!reset_n)
    state == RSSC_RUN && accepted |=> core_reset)
    else $error("qualified reset not taken");
  a_pin_drive_low: assert property ( // R4
    @(posedge ref_clk) disable iff (!reset_n)
    reset_pin_oe |-> !reset_pin_out)
    else $error("reset pin driven high");
  a_sync_start: assert property ( // R5
    @(posedge ref_clk) disable iff (!reset_n)
    state == RSSC_IN_RESET && next_state == RSSC_SYNC_WAIT |=>
    state == RSSC_SYNC_WAIT &&
    seq_cnt == STATE_CNT_W'(SYNC_DELAY_CYCLES - 1))
    else $error("sync delay not loaded with six cycles");
  a_no_short_reset: assert property ( // R11
    @(posedge ref_clk) disable iff (!reset_n)
    state == RSSC_RUN && !drive && low_cnt < STATE_CNT_W'(LOW_EDGES) |=>
    state != RSSC_IN_RESET)
    else $error("short low pulse caused reset");
  a_strap_floats: assert property ( // R7
    @(posedge ref_clk) disable iff (!reset_n)
    core_reset && !drv_sync[1] |=> !internal_exec)
    else $error("floating strap read high");
  a_phase_range: assert property ( // R8
    @(posedge ref_clk) disable iff (!reset_n)
    phase <= 2'(PHASE_COUNT - 1))
    else $error("illegal phase");
  a_instr_len: assert property ( // R5
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_instr_active) |->
    seq_cnt == STATE_CNT_W'(RESET_INSTR_STATES - 1))
    else $error("reset instruction length wrong");
  c_run: cover property (@(posedge ref_clk) state == RSSC_RUN);
  c_wdt: cover property (@(posedge ref_clk) watchdog_overflow ##1 latch);
  c_swrst: cover property (@(posedge ref_clk) software_reset ##1 reset_pin_oe);
endmodule // rssc_reset_ctrl

// ---- bench/rssc_board_model.sv ----
// Board side model: clock source and open-drain reset line with pull-up.
module rssc_board_model
(
  input wire logic reset_pin_oe,
  input wire logic ext_low,
  input wire logic hold_high,
  output logic clock_input_pin,
  output logic reset_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************************************************
  // Clock source and reset wire
  // ***********************************************************
  // 6.25 MHz source
  // The offset puts falling edges on the bench's driving edges.
  initial
  begin
    clock_input_pin = 1'b1;
    #40;
    forever #80 clock_input_pin = ~clock_input_pin;
  end
  assign reset_pin_in = ~ext_low & (hold_high | ~reset_pin_oe);
endmodule // rssc_board_model

// ---- bench/rssc_reset_ctrl_tb_top.sv ----
// Testbench for the reset and start-up control block.
module rssc_reset_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rssc_pkg::*;
  logic ref_clk, reset_n, cip, pin_in, strap, strap_drv, wd_ovf, wd_clr;
  logic sw_rst, standby, pin_out, pin_oe, latched, core_reset, instr;
  logic int_exec, hit, ext_low, hold_high;
  logic [7:0] rd;
  rssc_ram_req_t req;
  rssc_phase_t phases;
  int n_fail, checks, ticks, n;
  rssc_reset_ctrl uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .clock_input_pin(cip), .reset_pin_in(pin_in),
    .external_access_strap(strap), .strap_driven(strap_drv),
    .watchdog_overflow(wd_ovf), .watchdog_clear(wd_clr),
    .software_reset(sw_rst), .standby_supply_pin(standby), .ram_req(req),
    .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
    .pulldown_latched(latched), .core_reset(core_reset),
    .reset_instr_active(instr), .internal_exec(int_exec), .phases(phases),
    .ram_rd_data(rd), .ram_hit(hit));
  rssc_board_model board (.reset_pin_oe(pin_oe), .ext_low(ext_low),
    .hold_high(hold_high), .clock_input_pin(cip), .reset_pin_in(pin_in));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (phases.state_tick === 1'b1)
      ticks++;
  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task wait_instr(input logic v);
    n = 0;
    while (instr !== v && n < 600)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (instr !== v)
    begin
      n_fail++;
      $display("unexpected reset_instr_active: expected %b seen %b", v, instr);
    end
  endtask
  task pin_low(input int cycles);
    @(negedge cip);
    ext_low = 1'b1;
    repeat (cycles) @(negedge cip);
    ext_low = 1'b0;
  endtask
  task end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task t_sync;
    pin_low(3 * RESET_MIN_STATES);
    chk("core_reset held", 1, core_reset);
    chk("phase one-hot", 1, $onehot(phases[3:1]));
    wait_instr(1'b1);
    chk("sync start window", 1, n >= 24 && n <= 28);
    ticks = 0;
    wait_instr(1'b0);
    chk("reset instr ticks", RESET_INSTR_STATES, ticks);
  endtask
  task t_short;
    pin_low(2);
    repeat (40) @(negedge ref_clk);
    chk("short pulse ignored", 0, core_reset);
    pin_low(3 * RESET_MIN_STATES);
    repeat (3) @(negedge ref_clk);
    chk("pin reset taken", 1, core_reset);
    wait_instr(1'b1);
    wait_instr(1'b0);
  endtask
  task t_sw;
    sw_rst = 1'b1;
    @(negedge ref_clk);
    sw_rst = 1'b0;
    chk("self pull-down", 1, pin_oe);
    chk("pin drive level", 0, pin_out);
    n = 0;
    while (pin_oe === 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("drive length", 1, n >= 20 && n <= 24);
    wait_instr(1'b1);
    wait_instr(1'b0);
  endtask
  task t_wd;
    hold_high = 1'b1;
    wd_ovf = 1'b1;
    @(negedge ref_clk);
    wd_ovf = 1'b0;
    wd_clr = 1'b1;
    @(negedge ref_clk);
    wd_clr = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("latch after clear", 1, latched);
    chk("pull-down on", 1, pin_oe);
    hold_high = 1'b0;
    wait_instr(1'b1);
    wait_instr(1'b0);
  endtask
  task t_strap;
    ext_low = 1'b1;
    strap_drv = 1'b0;
    strap = 1'b1;
    repeat (60) @(negedge ref_clk);
    chk("floating strap", 0, int_exec);
    strap_drv = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("strap high", 1, int_exec);
    strap = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("strap low", 0, int_exec);
    strap = 1'b1;
    pin_low(1);
    wait_instr(1'b1);
    wait_instr(1'b0);
  endtask
  task t_ram;
    standby = 1'b1;
    req = '{wr: 1'b1, addr: 8'hf3, data: 8'ha5};
    @(negedge ref_clk);
    req.wr = 1'b0;
    standby = 1'b0;
    repeat (3) @(negedge ref_clk);
    req = '{wr: 1'b1, addr: 8'hf3, data: 8'h5a};
    @(negedge ref_clk);
    standby = 1'b1;
    req.wr = 1'b0;
    @(negedge ref_clk);
    chk("retained data", 8'ha5, rd);
    chk("window hit", 1, hit);
    req.addr = 8'h42;
    @(negedge ref_clk);
    chk("outside window", 0, hit);
  endtask
  initial
  begin
    {reset_n, strap, strap_drv, wd_ovf, wd_clr, sw_rst} = 6'h18;
    {ext_low, hold_high, standby} = 3'h5;
    req = '0;
    n_fail = 0;
    checks = 0;
    ticks = 0;
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    t_sync();
    t_short();
    t_sw();
    t_wd();
    t_strap();
    t_ram();
    end_of_test();
  end
  initial
  begin
    #2ms;
    n_fail++;
    end_of_test();
  end
endmodule // rssc_reset_ctrl_tb_top
